// *** hdl/sbc_buf_ctrl.sv ***
/*
 * SDRAM write buffer and read-buffer prefetch control, with the
 * buffer control register. Assumes masters and the SDRAM controller
 * are synchronous to clock; read data itself travels outside.
 */
// Operation
// - write buffer and prefetch enabled separately
// - 8-bit control register at 40h, resets zero
// - programmable reset clears the control register
// - prefetch off means no prefetching
// - burst read prefetches next line too
// - single read fetches rest of line only
// - prefetch for bursts from any source but DMA
// - watermark code selects 28/24/16/8 doublewords
// - new rank only when write cannot merge
// - buffer writes only while enabled, else bypass
// - flush bit starts flush, reads 1 meanwhile
// - flush drains before any other SDRAM access
`timescale 1ns/1ps
module sbc_buf_ctrl
    import sbc_pkg::*;
(
    input  wire logic                       clock,
    input  wire logic                       rst_b,
    input  wire logic                       prog_rst,
    input  wire logic [11:0]                cfg_addr,
    input  wire logic                       cfg_wr,
    input  wire logic                       cfg_rd,
    input  wire logic [7:0]                 cfg_wdata,
    output logic [7:0]                      cfg_rdata,
    input  wire logic                       mw_valid,
    output logic                            mw_ready,
    input  wire logic [sbc_pkg::SBC_AW-1:0] mw_addr,
    input  wire logic [31:0]                mw_data,
    input  wire logic [3:0]                 mw_be,
    input  wire logic                       mr_valid,
    output logic                            mr_ready,
    input  wire logic [sbc_pkg::SBC_AW-1:0] mr_addr,
    input  wire logic                       mr_burst,
    input  wire logic [1:0]                 mr_src,
    output logic                            mr_done,
    output logic                            mr_hit,
    output logic                            wb_svc_req,
    output logic                            sd_wr_valid,
    input  wire logic                       sd_wr_ready,
    output logic [sbc_pkg::SBC_AW-1:0]      sd_wr_addr,
    output logic [31:0]                     sd_wr_data,
    output logic [3:0]                      sd_wr_be,
    output logic                            sd_rd_valid,
    input  wire logic                       sd_rd_ready,
    output logic [sbc_pkg::SBC_LW-1:0]      sd_rd_line,
    output logic [1:0]                      sd_rd_start
);
    import sbc_pkg::*;

    logic [7:0]          ctrl_q, ctrl_d;
    logic [7:0]          rdata_q, rdata_d;
    logic                svc_q, svc_d;
    logic [5:0]          count_q, count_d;
    logic [4:0]          head_q, head_d, tail_q, tail_d;
    logic [SBC_AW-1:0]   rk_addr [0:SBC_DEPTH-1];
    logic [31:0]         rk_data [0:SBC_DEPTH-1];
    logic [3:0]          rk_be   [0:SBC_DEPTH-1];
    logic                cfg_hit, wb_on, flushing, pref_on, drained;
    logic                mhit, pop, wr_take, alloc;
    logic [4:0]          hidx, widx, rel;
    logic [31:0]         wdat;
    logic [3:0]          wbe;
    logic                sk_in_valid, sk_in_ready;
    logic [SBC_WB_W-1:0] sk_in_data;

    assign cfg_hit  = (cfg_addr == SBC_CTRL_OFF);
    assign wb_on    = ctrl_q[SBC_ON_BIT];
    assign flushing = ctrl_q[SBC_FLUSH_BIT];
    assign pref_on  = ctrl_q[SBC_PREF_BIT];
    assign drained  = (count_q == 6'h0) && !sd_wr_valid;

    // control register
    always_comb
    begin
        ctrl_d  = ctrl_q;
        rdata_d = rdata_q;
        if (flushing && drained)
            ctrl_d[SBC_FLUSH_BIT] = 1'h0;
        if (cfg_wr && cfg_hit)
        begin
            ctrl_d[SBC_ON_BIT]   = cfg_wdata[SBC_ON_BIT];
            ctrl_d[SBC_PREF_BIT] = cfg_wdata[SBC_PREF_BIT];
            ctrl_d[SBC_THR_HI:SBC_THR_LO] = cfg_wdata[SBC_THR_HI:SBC_THR_LO];
            // a new flush request wins over a finishing one
            if (cfg_wdata[SBC_FLUSH_BIT])
                ctrl_d[SBC_FLUSH_BIT] = 1'h1;
        end
        ctrl_d[7:5] = SBC_RSV_RD;
        if (prog_rst)
            ctrl_d = SBC_CTRL_RST;
        if (cfg_rd)
            rdata_d = cfg_hit ? ctrl_q : 8'h00;
    end

    // merge search over allocated ranks only
    always_comb
    begin
        mhit = 1'h0;
        hidx = 5'h0;
        rel  = 5'h0;
        for (int i = 0; i < SBC_DEPTH; i++)
        begin
            rel = 5'(i) - head_q;
            if (!mhit && ({1'h0, rel} < count_q) && (rk_addr[i] == mw_addr))
            begin
                mhit = 1'h1;
                hidx = 5'(i);
            end
        end
    end

    always_comb
    begin
        // drain when above watermark, flushing, or buffer switched off
        pop = (count_q != 6'h0) && (flushing || !wb_on || svc_q) && sk_in_ready;
        // writes wait out a flush; merging into the rank leaving now would lose bytes
        if (flushing)
            mw_ready = 1'h0;
        else if (wb_on)
            mw_ready = mhit ? !(pop && hidx == head_q) : (count_q != SBC_DEPTH_CNT);
        else
            mw_ready = (count_q == 6'h0) && sk_in_ready;
        wr_take = mw_valid && mw_ready;
        alloc   = wr_take && wb_on && !mhit;
        widx    = mhit ? hidx : tail_q;
        for (int b = 0; b < 4; b++)
            wdat[b*8 +: 8] = (mw_be[b] || !mhit) ? mw_data[b*8 +: 8] : rk_data[widx][b*8 +: 8];
        wbe     = mhit ? (rk_be[widx] | mw_be) : mw_be;
        count_d = count_q + {5'h0, alloc} - {5'h0, pop};
        head_d  = head_q + {4'h0, pop};
        tail_d  = tail_q + {4'h0, alloc};
        svc_d   = count_d > sbc_thr_dw(ctrl_d[SBC_THR_HI:SBC_THR_LO]);
        sk_in_valid = pop || (wr_take && !wb_on);
        sk_in_data  = pop ? {rk_addr[head_q], rk_data[head_q], rk_be[head_q]}
                          : {mw_addr, mw_data, mw_be};
    end

    always_ff @(posedge clock)
    begin
        if (wr_take && wb_on)
        begin
            rk_addr[widx] <= mw_addr;
            rk_data[widx] <= wdat;
            rk_be[widx]   <= wbe;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q  <= SBC_CTRL_RST;
            rdata_q <= 8'h00;
            svc_q   <= 1'h0;
            count_q <= 6'h0;
            head_q  <= 5'h0;
            tail_q  <= 5'h0;
        end
        else
        begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
            svc_q   <= svc_d;
            count_q <= count_d;
            head_q  <= head_d;
            tail_q  <= tail_d;
        end
    end

    assign cfg_rdata  = rdata_q;
    assign wb_svc_req = svc_q;

    sbc_skid #(
        .W (SBC_WB_W)
    ) u_skid (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (sk_in_valid),
        .in_ready  (sk_in_ready),
        .in_data   (sk_in_data),
        .out_valid (sd_wr_valid),
        .out_ready (sd_wr_ready),
        .out_data  ({sd_wr_addr, sd_wr_data, sd_wr_be})
    );

    // read buffer: line just fetched and line prefetched
    sbc_rd_state_t      rd_q, rd_d;
    logic [SBC_LW-1:0]  line_q, line_d, tag0_q, tag0_d, tag1_q, tag1_d;
    logic [1:0]         start_q, start_d;
    logic               pf_q, pf_d, v0_q, v0_d, v1_q, v1_d;
    logic               done_q, done_d, hit_q, hit_d, rb_hit;
    logic [SBC_LW-1:0]  mr_line, mw_line;

    assign mr_line = mr_addr[SBC_AW-1:2];
    assign mw_line = mw_addr[SBC_AW-1:2];
    assign rb_hit  = (v0_q && tag0_q == mr_line) || (v1_q && tag1_q == mr_line);

    always_comb
    begin
        rd_d    = rd_q;
        line_d  = line_q;
        start_d = start_q;
        pf_d    = pf_q;
        done_d  = 1'h0;
        hit_d   = 1'h0;
        tag0_d  = tag0_q;
        tag1_d  = tag1_q;
        // a write makes a held copy of its line stale
        v0_d    = v0_q && !(wr_take && tag0_q == mw_line);
        v1_d    = v1_q && !(wr_take && tag1_q == mw_line);
        mr_ready    = (rd_q == SBC_RD_IDLE) && !flushing;
        sd_rd_valid = (rd_q != SBC_RD_IDLE) && !flushing;
        unique case (rd_q)
            SBC_RD_IDLE:
                if (mr_valid && mr_ready)
                begin
                    if (rb_hit)
                    begin
                        done_d = 1'h1;
                        hit_d  = 1'h1;
                    end
                    else
                    begin
                        line_d  = mr_line;
                        start_d = mr_addr[1:0];
                        pf_d    = pref_on && mr_burst && (mr_src != SBC_SRC_DMA);
                        rd_d    = SBC_RD_FETCH;
                    end
                end
            SBC_RD_FETCH:
                if (sd_rd_valid && sd_rd_ready)
                begin
                    tag0_d = line_q;
                    v0_d   = 1'h1;
                    if (pf_q)
                    begin
                        line_d  = line_q + 24'h1;
                        start_d = 2'h0;
                        rd_d    = SBC_RD_PREF;
                    end
                    else
                    begin
                        done_d = 1'h1;
                        rd_d   = SBC_RD_IDLE;
                    end
                end
            SBC_RD_PREF:
                if (sd_rd_valid && sd_rd_ready)
                begin
                    tag1_d = line_q;
                    v1_d   = 1'h1;
                    pf_d   = 1'h0;
                    done_d = 1'h1;
                    rd_d   = SBC_RD_IDLE;
                end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_q    <= SBC_RD_IDLE;
            line_q  <= 24'h0;
            start_q <= 2'h0;
            pf_q    <= 1'h0;
            done_q  <= 1'h0;
            hit_q   <= 1'h0;
            tag0_q  <= 24'h0;
            tag1_q  <= 24'h0;
            v0_q    <= 1'h0;
            v1_q    <= 1'h0;
        end
        else
        begin
            rd_q    <= rd_d;
            line_q  <= line_d;
            start_q <= start_d;
            pf_q    <= pf_d;
            done_q  <= done_d;
            hit_q   <= hit_d;
            tag0_q  <= tag0_d;
            tag1_q  <= tag1_d;
            v0_q    <= v0_d;
            v1_q    <= v1_d;
        end
    end

    assign sd_rd_line  = line_q;
    assign sd_rd_start = start_q;
    assign mr_done     = done_q;
    assign mr_hit      = hit_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    logic rd_take;
    assign rd_take = mr_valid && mr_ready;

    property p_fields;
        cfg_wr && cfg_hit && !prog_rst |=> wb_on == $past(cfg_wdata[0])
            && pref_on == $past(cfg_wdata[4]);
    endproperty
    a_fields: assert property (p_fields) else $error("enable bits not written");
    property p_readback;
        cfg_rd && cfg_hit |=> cfg_rdata == {3'h0, $past(ctrl_q[4:0])};
    endproperty
    a_readback: assert property (p_readback) else $error("bad control readback");
    property p_prog;
        prog_rst |=> ctrl_q == 8'h00;
    endproperty
    a_prog: assert property (p_prog) else $error("programmable reset kept bits");
    property p_nopref;
        rd_take && !rb_hit && (!pref_on || !mr_burst || mr_src == SBC_SRC_DMA) |=> !pf_q
            ##1 rd_q != SBC_RD_PREF;
    endproperty
    a_nopref: assert property (p_nopref) else $error("prefetch not allowed");
    property p_pref;
        rd_take && !rb_hit && pref_on && mr_burst && mr_src == SBC_SRC_CPU
            |=> pf_q && line_q == $past(mr_line);
    endproperty
    a_pref: assert property (p_pref) else $error("burst prefetch missing");
    property p_single;
        rd_take && !rb_hit && !mr_burst |=> start_q == $past(mr_addr[1:0]) && !pf_q;
    endproperty
    a_single: assert property (p_single) else $error("single read fetch wrong");
    property p_thr8;
        ctrl_q[3:2] == 2'h3 && count_q == 6'h09 |-> svc_q;
    endproperty
    a_thr8: assert property (p_thr8) else $error("watermark 8 not honoured");
    property p_svc;
        svc_q == (count_q > sbc_thr_dw(ctrl_q[3:2]));
    endproperty
    a_svc: assert property (p_svc) else $error("service request mismatch");
    property p_merge;
        wr_take && wb_on && mhit && !pop |=> count_q == $past(count_q);
    endproperty
    a_merge: assert property (p_merge) else $error("merge allocated a rank");
    property p_bypass;
        wr_take && !wb_on |=> count_q == 6'h0 && sd_wr_valid;
    endproperty
    a_bypass: assert property (p_bypass) else $error("disabled write was buffered");
    property p_flush;
        flushing && !drained && !prog_rst |=> flushing;
    endproperty
    a_flush: assert property (p_flush) else $error("flush bit cleared early");
    property p_flprio;
        flushing |-> !sd_rd_valid && !mw_ready && !mr_ready;
    endproperty
    a_flprio: assert property (p_flprio) else $error("access during flush");
    property p_hit;
        rd_take && rb_hit |=> mr_hit && mr_done && rd_q == SBC_RD_IDLE;
    endproperty
    a_hit: assert property (p_hit) else $error("hit caused fetch");

    c_prefetch: cover property (rd_q == SBC_RD_PREF && sd_rd_ready);
    c_flush: cover property (flushing ##1 !flushing);
    c_merge: cover property (wr_take && wb_on && mhit);
    c_svc: cover property (!svc_q ##1 svc_q);

endmodule

// *** hdl/sbc_pkg.sv ***
/*
 * Shared constants for the SDRAM write/read buffer control block:
 * control register location and layout, watermark levels, master
 * source codes, read-fetch states and widths.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package sbc_pkg;

    // control register within the configuration region
    localparam logic [11:0] SBC_CTRL_OFF   = 12'h040;
    localparam logic [7:0]  SBC_CTRL_RST   = 8'h00;
    localparam int          SBC_ON_BIT     = 0;
    localparam int          SBC_FLUSH_BIT  = 1;
    localparam int          SBC_THR_LO     = 2;
    localparam int          SBC_THR_HI     = 3;
    localparam int          SBC_PREF_BIT   = 4;
    localparam logic [2:0]  SBC_RSV_RD     = 3'h0;

    // watermark levels in doublewords
    localparam logic [5:0]  SBC_THR_28     = 6'h1c;
    localparam logic [5:0]  SBC_THR_24     = 6'h18;
    localparam logic [5:0]  SBC_THR_16     = 6'h10;
    localparam logic [5:0]  SBC_THR_8      = 6'h08;

    // write buffer: one rank per doubleword
    localparam int          SBC_DEPTH      = 32;
    localparam logic [5:0]  SBC_DEPTH_CNT  = 6'h20;
    localparam int          SBC_AW         = 26;
    localparam int          SBC_LW         = 24;
    localparam int          SBC_WB_W       = SBC_AW + 32 + 4;

    // requesting master
    localparam logic [1:0]  SBC_SRC_CPU    = 2'h0;
    localparam logic [1:0]  SBC_SRC_PCI    = 2'h1;
    localparam logic [1:0]  SBC_SRC_DMA    = 2'h2;

    typedef enum logic [2:0] {
        SBC_RD_IDLE  = 3'h1,
        SBC_RD_FETCH = 3'h2,
        SBC_RD_PREF  = 3'h4
    } sbc_rd_state_t;

    function automatic logic [5:0] sbc_thr_dw(input logic [1:0] f);
        logic [5:0] t;
        t = SBC_THR_28;
        unique case (f)
            2'h0: t = SBC_THR_28;
            2'h1: t = SBC_THR_24;
            2'h2: t = SBC_THR_16;
            2'h3: t = SBC_THR_8;
        endcase
        return t;
    endfunction

endpackage

// *** hdl/sbc_skid.sv ***
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock; a stall on the output side back-pressures input.
 */
`timescale 1ns/1ps
module sbc_skid #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem [0:1];
    logic         wp_q;
    logic         wp_d;
    logic         rp_q;
    logic         rp_d;
    logic [1:0]   cnt_q;
    logic [1:0]   cnt_d;
    logic         push;
    logic         pull;

    always_comb
    begin
        in_ready  = (cnt_q != 2'h2);
        out_valid = (cnt_q != 2'h0);
        out_data  = mem[rp_q];
        push      = in_valid && in_ready;
        pull      = out_valid && out_ready;
        wp_d      = push ? ~wp_q : wp_q;
        rp_d      = pull ? ~rp_q : rp_q;
        cnt_d     = cnt_q + {1'h0, push} - {1'h0, pull};
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_q  <= 1'h0;
            rp_q  <= 1'h0;
            cnt_q <= 2'h0;
        end
        else
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // storage carries no reset; validity lives in cnt_q
    always_ff @(posedge clock)
    begin
        if (push)
            mem[wp_q] <= in_data;
    end

endmodule

// *** test/sbc_sdram_model.sv ***
/*
 * Behavioural SDRAM-controller side of the buffer control block: takes
 * write words and line-fetch requests and logs them in order.
 * Assumes the bench stalls either channel through the stall inputs.
 */
`timescale 1ns/1ps
module sbc_sdram_model (
    input  wire logic                       clock,
    input  wire logic                       stall_wr,
    input  wire logic                       stall_rd,
    input  wire logic                       sd_wr_valid,
    output logic                            sd_wr_ready,
    input  wire logic [sbc_pkg::SBC_AW-1:0] sd_wr_addr,
    input  wire logic [31:0]                sd_wr_data,
    input  wire logic [3:0]                 sd_wr_be,
    input  wire logic                       sd_rd_valid,
    output logic                            sd_rd_ready,
    input  wire logic [sbc_pkg::SBC_LW-1:0] sd_rd_line,
    input  wire logic [1:0]                 sd_rd_start
);
    import sbc_pkg::*;

    logic [31:0]       wr_data_q [$];
    logic [3:0]        wr_be_q [$];
    logic [SBC_AW-1:0] wr_addr_q [$];
    logic [SBC_LW-1:0] rd_line_q [$];
    logic [1:0]        rd_start_q [$];

    // a stalled controller withholds ready; the block must hold its request
    assign sd_wr_ready = !stall_wr;
    assign sd_rd_ready = !stall_rd;

    always @(posedge clock)
    begin
        if (sd_wr_valid && sd_wr_ready)
        begin
            wr_data_q.push_back(sd_wr_data);
            wr_be_q.push_back(sd_wr_be);
            wr_addr_q.push_back(sd_wr_addr);
        end
        if (sd_rd_valid && sd_rd_ready)
        begin
            rd_line_q.push_back(sd_rd_line);
            rd_start_q.push_back(sd_rd_start);
        end
    end
endmodule

// *** test/sbc_buf_ctrl_tb.sv ***
/*
 * Self-checking bench for the buffer control block: register access,
 * bypass and buffered writes, watermarks, flush and read prefetch.
 * Assumes the SDRAM-side model file and the package are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module sbc_buf_ctrl_tb;
    import sbc_pkg::*;

    logic              clock, rst_b, prog_rst, cfg_wr, cfg_rd;
    logic [11:0]       cfg_addr;
    logic [7:0]        cfg_wdata, cfg_rdata;
    logic              mw_valid, mw_ready, mr_valid, mr_ready, mr_burst, mr_done, mr_hit;
    logic [SBC_AW-1:0] mw_addr, mr_addr, sd_wr_addr;
    logic [31:0]       mw_data, sd_wr_data;
    logic [3:0]        mw_be, sd_wr_be;
    logic [1:0]        mr_src, sd_rd_start;
    logic              wb_svc_req, sd_wr_valid, sd_wr_ready, sd_rd_valid, sd_rd_ready;
    logic [SBC_LW-1:0] sd_rd_line;
    logic              stall_wr, stall_rd;
    int                mismatches, checked;

    sbc_buf_ctrl u_dut (.clock(clock), .rst_b(rst_b), .prog_rst(prog_rst),
        .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .mw_valid(mw_valid), .mw_ready(mw_ready), .mw_addr(mw_addr),
        .mw_data(mw_data), .mw_be(mw_be), .mr_valid(mr_valid), .mr_ready(mr_ready),
        .mr_addr(mr_addr), .mr_burst(mr_burst), .mr_src(mr_src), .mr_done(mr_done),
        .mr_hit(mr_hit), .wb_svc_req(wb_svc_req), .sd_wr_valid(sd_wr_valid),
        .sd_wr_ready(sd_wr_ready), .sd_wr_addr(sd_wr_addr), .sd_wr_data(sd_wr_data),
        .sd_wr_be(sd_wr_be), .sd_rd_valid(sd_rd_valid), .sd_rd_ready(sd_rd_ready),
        .sd_rd_line(sd_rd_line), .sd_rd_start(sd_rd_start));

    sbc_sdram_model u_sd (.clock(clock), .stall_wr(stall_wr), .stall_rd(stall_rd),
        .sd_wr_valid(sd_wr_valid), .sd_wr_ready(sd_wr_ready), .sd_wr_data(sd_wr_data),
        .sd_wr_addr(sd_wr_addr), .sd_wr_be(sd_wr_be), .sd_rd_valid(sd_rd_valid),
        .sd_rd_ready(sd_rd_ready),
        .sd_rd_line(sd_rd_line), .sd_rd_start(sd_rd_start));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cfg_access(input logic wr, input logic [11:0] a, input logic [7:0] d,
                              output logic [7:0] q);
        @(posedge clock);
        #1;
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = wr;
        cfg_rd = !wr;
        @(posedge clock);
        #1;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        @(posedge clock);
        #1;
        q = cfg_rdata;
    endtask

    task automatic mwrite(input logic [SBC_AW-1:0] a, input logic [31:0] d,
                          input logic [3:0] be);
        int n;
        @(posedge clock);
        #1;
        mw_addr = a;
        mw_data = d;
        mw_be = be;
        mw_valid = 1'b1;
        for (n = 0; n < 500 && mw_ready !== 1'b1; n++)
        begin
            @(posedge clock);
            #1;
        end
        `CHK("mw_ready", 1'b1, mw_ready)
        @(posedge clock);
        #1;
        mw_valid = 1'b0;
    endtask

    // register traffic with idle cycles between accesses, reserved bits, unmapped place, programmable reset
    task automatic t_regs();
        logic [7:0] r;
        cfg_access(1'b0, SBC_CTRL_OFF, 8'h00, r);
        `CHK("ctrl reset", SBC_CTRL_RST, r)
        cfg_access(1'b1, SBC_CTRL_OFF, 8'hfd, r);
        cfg_access(1'b1, 12'h044, 8'h00, r);
        cfg_access(1'b0, SBC_CTRL_OFF, 8'h00, r);
        `CHK("ctrl fields", 8'h1d, r)
        cfg_access(1'b0, 12'h044, 8'h00, r);
        `CHK("unmapped", 8'h00, r)
        prog_rst = 1'b1;
        @(posedge clock);
        #1;
        prog_rst = 1'b0;
        cfg_access(1'b0, SBC_CTRL_OFF, 8'h00, r);
        `CHK("prog reset", 8'h00, r)
    endtask

    task automatic t_bypass();
        int b, n;
        b = u_sd.wr_data_q.size();
        mwrite(26'h0000100, 32'hcafe1234, 4'hf);
        for (n = 0; n < 50 && u_sd.wr_data_q.size() == b; n++)
            @(posedge clock);
        #1;
        `CHK("bypass data", 32'hcafe1234, u_sd.wr_data_q[b])
        `CHK("bypass svc", 1'b0, wb_svc_req)
    endtask

    task automatic t_watermark();
        int thr_tab [4] = '{28, 24, 16, 8};
        int b, n, i;
        logic [7:0] r;
        for (int c = 0; c < 4; c++)
        begin
            stall_wr = 1'b1;
            cfg_access(1'b1, SBC_CTRL_OFF, {4'h0, c[1:0], 2'h0}, r);
            cfg_access(1'b1, SBC_CTRL_OFF, {4'h0, c[1:0], 2'h1}, r);
            b = u_sd.wr_data_q.size();
            mwrite(26'h0001000, 32'h000000a5, 4'h1);
            for (i = 1; i < thr_tab[c]; i++)
                mwrite(26'h0001000 + i, i, 4'hf);
            mwrite(26'h0001000, 32'h00005a00, 4'h2);
            @(posedge clock);
            #1;
            `CHK("svc at mark", 1'b0, wb_svc_req)
            mwrite(26'h0001000 + thr_tab[c], 32'h0, 4'hf);
            for (n = 0; n < 3 && wb_svc_req !== 1'b1; n++)
            begin
                @(posedge clock);
                #1;
            end
            `CHK("svc above mark", 1'b1, wb_svc_req)
            cfg_access(1'b1, SBC_CTRL_OFF, {4'h0, c[1:0], 2'h0}, r);
            stall_wr = 1'b0;
            for (n = 0; n < 300 && u_sd.wr_data_q.size() - b < thr_tab[c] + 1; n++)
                @(posedge clock);
            #1;
            `CHK("ranks drained", thr_tab[c] + 1, u_sd.wr_data_q.size() - b)
            `CHK("merged be", 4'h3, u_sd.wr_be_q[b])
            `CHK("drain addr", 26'h0001000, u_sd.wr_addr_q[b])
            `CHK("merged data", 16'h5aa5, u_sd.wr_data_q[b][15:0])
        end
    endtask

    task automatic t_flush();
        int b, n;
        logic [7:0] r;
        stall_wr = 1'b1;
        cfg_access(1'b1, SBC_CTRL_OFF, 8'h01, r);
        b = u_sd.wr_data_q.size();
        for (int i = 0; i < 4; i++)
            mwrite(26'h0002000 + i, i, 4'hf);
        cfg_access(1'b1, SBC_CTRL_OFF, 8'h03, r);
        cfg_access(1'b1, SBC_CTRL_OFF, 8'h01, r);
        cfg_access(1'b0, SBC_CTRL_OFF, 8'h00, r);
        `CHK("flush busy", 8'h03, r)
        `CHK("reads held off", 1'b0, mr_ready)
        stall_wr = 1'b0;
        for (n = 0; n < 50 && r[1] !== 1'b0; n++)
            cfg_access(1'b0, SBC_CTRL_OFF, 8'h00, r);
        `CHK("flush done", 8'h01, r)
        `CHK("flushed words", 4, u_sd.wr_data_q.size() - b)
        cfg_access(1'b1, SBC_CTRL_OFF, 8'h00, r);
    endtask

    task automatic t_reads();
        logic [SBC_LW-1:0] ln [6] = '{24'h10, 24'h20, 24'h30, 24'h31, 24'h50, 24'h60};
        logic       pf [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        logic       bu [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        logic [1:0] sr [6] = '{SBC_SRC_CPU, SBC_SRC_CPU, SBC_SRC_CPU, SBC_SRC_CPU,
                               SBC_SRC_PCI, SBC_SRC_DMA};
        int         nf [6] = '{1, 1, 2, 0, 2, 1};
        logic [7:0] r;
        int         b, n;
        for (int k = 0; k < 6; k++)
        begin
            cfg_access(1'b1, SBC_CTRL_OFF, {3'h0, pf[k], 4'h0}, r);
            b = u_sd.rd_line_q.size();
            stall_rd = (k == 2);
            @(posedge clock);
            #1;
            mr_addr = {ln[k], 2'h1};
            mr_burst = bu[k];
            mr_src = sr[k];
            mr_valid = 1'b1;
            for (n = 0; n < 500 && mr_ready !== 1'b1; n++)
            begin
                @(posedge clock);
                #1;
            end
            @(posedge clock);
            #1;
            mr_valid = 1'b0;
            // a stalled fetch is released after three edges; done is a one-cycle pulse
            for (n = 0; n < 500 && mr_done !== 1'b1; n++)
            begin
                stall_rd = stall_rd && (n < 3);
                @(posedge clock);
                #1;
            end
            `CHK("mr_done", 1'b1, mr_done)
            `CHK("mr_hit", nf[k] == 0, mr_hit)
            `CHK("fetches", nf[k], u_sd.rd_line_q.size() - b)
            if (nf[k] > 0)
            begin
                `CHK("fetch line", ln[k], u_sd.rd_line_q[b])
                `CHK("fetch start", 2'h1, u_sd.rd_start_q[b])
            end
            if (nf[k] > 1)
            begin
                `CHK("prefetch line", ln[k] + 24'h1, u_sd.rd_line_q[b + 1])
                `CHK("prefetch start", 2'h0, u_sd.rd_start_q[b + 1])
            end
        end
    endtask

    initial
    begin
        #500000;
        mismatches++;
        stop_test();
    end

    initial
    begin
        {rst_b, prog_rst, cfg_wr, cfg_rd, mw_valid, mr_valid, mr_burst} = 7'h0;
        {cfg_addr, cfg_wdata, mw_addr, mw_data, mw_be, mr_addr, mr_src} = '0;
        {stall_wr, stall_rd} = 2'h0;
        mismatches = 0;
        checked = 0;
        repeat (12) @(posedge clock);
        #1;
        rst_b = 1'b1;
        t_regs();
        t_bypass();
        t_watermark();
        t_flush();
        t_reads();
        stop_test();
    end
endmodule
